// *** rtl/cmm_cache.sv ***
`timescale 1ns/1ps
// Functional notes
// - fetches during tag clear wait, then serviced
// - soft reset clears tags, keeps registers
// - hard reset: defaults, full tag clear
// - line length 8, 16 or 32 bytes
// - interval counted in clocks, up to 10ms
// - hit total readable per interval
// - miss total readable per interval
// - threshold reached raises interrupt
// - monitor counts only in active mode
// - line request three cycles after miss
// - fill controller starts access two cycles later
// - flash read: phases plus two per byte
// - word returned four cycles after line data
// - otp burst starts two cycles after request
// - otp read length/4, same fixed delays
module cmm_cache
  import cmm_pkg::*;
#(
  parameter int TAG_INDEX_W = 9
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_addr,
  input wire logic fetch_src,
  output logic fetch_ready,
  input wire logic sys_active,
  output logic irq,
  cmm_link_if.dev link
);
  generate
    if (TAG_INDEX_W < 2 || TAG_INDEX_W > 12) begin : g_chk
      $error("cmm_cache: TAG_INDEX_W out of range");
    end
  endgenerate

  localparam int TAG_N = 1 << TAG_INDEX_W;
  localparam logic [TAG_INDEX_W-1:0] TAG_LAST = TAG_INDEX_W'(TAG_N - 1);
  typedef struct packed {
    logic valid;
    logic [1:0] size;
    logic [28:0] line;
  } cmm_tag_s;
  // p_size holds the line size of the pending miss, so a config write mid-fill
  // cannot move the link fields or mis-tag the returning line
  typedef struct packed {
    cmm_dev_st_e st;
    logic [2:0] cnt;
    logic [TAG_INDEX_W-1:0] clr_idx;
    logic [31:0] p_addr;
    logic p_src, line_req;
    logic [1:0] p_size, line_cfg;
    logic mon_en;
    logic [31:0] interval, thresh, tick, hits, misses, hit_q, miss_q;
    logic fired;
    logic [1:0] irq_stat, irq_en;
    logic dp, dp_wr;
    logic [7:0] dp_addr;
    logic rd_ok;
    logic [31:0] hrdata;
  } cmm_dev_s;
  cmm_dev_s s_reg, s_next;
  cmm_tag_s tag_mem [TAG_N];
  cmm_tag_s tag_rd, tag_wd;
  logic tag_we, take, wr_now, hit_ev, miss_ev;
  logic [TAG_INDEX_W-1:0] tag_wi;
  logic [28:0] f_line, p_line;
  logic [1:0] irq_set, irq_clr;
  logic [31:0] misses_new, hits_new, rd_mux;
  // ----------------------------------------------------------------
  // lookup
  // ----------------------------------------------------------------
  always_comb begin
    f_line = 29'(fetch_addr >> (CMM_MIN_LINE_SHIFT + int'(s_reg.line_cfg)));
    p_line = 29'(s_reg.p_addr >> (CMM_MIN_LINE_SHIFT + int'(s_reg.p_size)));
    tag_rd = tag_mem[f_line[TAG_INDEX_W-1:0]];
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // reads take one wait state so hrdata comes straight from a flop
  assign take = hsel && htrans[1] && hready;
  assign wr_now = s_reg.dp && s_reg.dp_wr;
  assign hreadyout = !(s_reg.dp && !s_reg.dp_wr && !s_reg.rd_ok);
  assign hrdata = s_reg.hrdata;
  assign hresp = 1'b0;
  assign irq_clr = (wr_now && s_reg.dp_addr == CMM_IRQ_CLR_OFS) ? hwdata[1:0] : 2'h0;

  always_comb begin
    unique case (s_reg.dp_addr)
      CMM_CTRL_OFS: rd_mux = {31'h0, s_reg.mon_en};
      CMM_LINE_CFG_OFS: rd_mux = {30'h0, s_reg.line_cfg};
      CMM_INTERVAL_OFS: rd_mux = s_reg.interval;
      CMM_THRESH_OFS: rd_mux = s_reg.thresh;
      CMM_HIT_CNT_OFS: rd_mux = s_reg.hit_q;
      CMM_MISS_CNT_OFS: rd_mux = s_reg.miss_q;
      CMM_IRQ_STAT_OFS: rd_mux = {30'h0, s_reg.irq_stat};
      CMM_IRQ_EN_OFS: rd_mux = {30'h0, s_reg.irq_en};
      CMM_STATUS_OFS: rd_mux = {29'h0, s_reg.st};
      default: rd_mux = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.line_req = 1'b0;
    fetch_ready = 1'b0;
    hit_ev = 1'b0;
    miss_ev = 1'b0;
    tag_we = 1'b0;
    tag_wi = s_reg.clr_idx;
    tag_wd = '0;
    irq_set = 2'h0;

    unique case (s_reg.st)
      CMM_CLEAR: begin
        // fetch_ready stays low: requests wait here
        tag_we = 1'b1;
        if (s_reg.clr_idx == TAG_LAST) begin
          s_next.st = CMM_IDLE;
        end
        s_next.clr_idx = s_reg.clr_idx + 1'b1;
      end
      CMM_IDLE: begin
        if (fetch_valid) begin
          if (tag_rd.valid && tag_rd.line == f_line && tag_rd.size == s_reg.line_cfg) begin
            fetch_ready = 1'b1;
            hit_ev = 1'b1;
          end else begin
            miss_ev = 1'b1;
            s_next.st = CMM_MISS;
            s_next.cnt = 3'h0;
            s_next.p_addr = fetch_addr;
            s_next.p_src = fetch_src;
            s_next.p_size = s_reg.line_cfg;
          end
        end
      end
      CMM_MISS: begin
        if (s_reg.cnt == 3'(CMM_MISS_TO_REQ_CYC - 2)) begin
          s_next.line_req = 1'b1;
          s_next.st = CMM_WAIT;
        end else begin
          s_next.cnt = s_reg.cnt + 3'h1;
        end
      end
      CMM_WAIT: begin
        if (link.line_done) begin
          s_next.st = CMM_RET;
          s_next.cnt = 3'h0;
          tag_we = 1'b1;
          tag_wi = p_line[TAG_INDEX_W-1:0];
          tag_wd = '{valid: 1'b1, size: s_reg.p_size, line: p_line};
        end
      end
      CMM_RET: begin
        if (s_reg.cnt == 3'(CMM_RETURN_CYC - 1)) begin
          fetch_ready = 1'b1;
          s_next.st = CMM_IDLE;
        end else begin
          s_next.cnt = s_reg.cnt + 3'h1;
        end
      end
      default: s_next.st = CMM_CLEAR;
    endcase
    // miss monitor
    hits_new = s_reg.hits + 32'(hit_ev);
    misses_new = s_reg.misses + 32'(miss_ev);
    if (s_reg.mon_en && sys_active && s_reg.interval != 32'h0) begin
      s_next.hits = hits_new;
      s_next.misses = misses_new;
      if (miss_ev && !s_reg.fired && misses_new == s_reg.thresh
          && s_reg.thresh != 32'h0) begin
        irq_set[CMM_IRQ_THRESH_BIT] = 1'b1;
        s_next.fired = 1'b1;
      end
      if (s_reg.tick >= s_reg.interval - 32'h1) begin
        s_next.tick = 32'h0;
        s_next.hit_q = hits_new;
        s_next.miss_q = misses_new;
        s_next.hits = 32'h0;
        s_next.misses = 32'h0;
        s_next.fired = 1'b0;
        irq_set[CMM_IRQ_INTERVAL_BIT] = 1'b1;
      end else begin
        s_next.tick = s_reg.tick + 32'h1;
      end
    end
    // sticky status: a new event beats a clear in the same cycle
    s_next.irq_stat = (s_reg.irq_stat & ~irq_clr) | irq_set;
    // bus slave
    s_next.rd_ok = 1'b0;
    if (take) begin
      s_next.dp = 1'b1;
      s_next.dp_wr = hwrite;
      s_next.dp_addr = haddr[7:0];
    end else if (s_reg.dp && hreadyout) begin
      s_next.dp = 1'b0;
    end
    if (s_reg.dp && !s_reg.dp_wr && !s_reg.rd_ok) begin
      s_next.rd_ok = 1'b1;
      s_next.hrdata = rd_mux;
    end
    if (wr_now) begin
      unique case (s_reg.dp_addr)
        CMM_CTRL_OFS: begin
          s_next.mon_en = hwdata[CMM_CTRL_MON_EN_BIT];
          if (hwdata[CMM_CTRL_SOFT_RST_BIT]) begin
            s_next.st = CMM_CLEAR;
            s_next.clr_idx = '0;
            s_next.line_req = 1'b0;
          end
        end
        CMM_LINE_CFG_OFS: begin
          // the unused code is refused so the line never exceeds 32 bytes
          if (hwdata[1:0] != 2'h3) begin
            s_next.line_cfg = hwdata[1:0];
          end
        end
        CMM_INTERVAL_OFS: begin
          s_next.interval = (hwdata > CMM_INTERVAL_RST) ? CMM_INTERVAL_RST : hwdata;
          s_next.tick = 32'h0;
        end
        CMM_THRESH_OFS: s_next.thresh = hwdata;
        CMM_IRQ_EN_OFS: s_next.irq_en = hwdata[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
      s_reg.st <= CMM_CLEAR;
      s_reg.line_cfg <= CMM_LINE_8;
      s_reg.interval <= CMM_INTERVAL_RST;
      s_reg.thresh <= CMM_THRESH_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // tag ram has no reset; the clear walk invalidates it
  always_ff @(posedge hclk) begin
    if (tag_we) begin
      tag_mem[tag_wi] <= tag_wd;
    end
  end

  assign irq = |(s_reg.irq_stat & s_reg.irq_en);
  assign link.line_req = s_reg.line_req;
  assign link.line_src = s_reg.p_src;
  assign link.line_size = s_reg.p_size;
  assign link.line_addr = s_reg.p_addr;
endmodule : cmm_cache

// *** rtl/cmm_fill.sv ***
`timescale 1ns/1ps
module cmm_fill
  import cmm_pkg::*;
#(
  parameter int FL_CMD_CYC = CMM_FL_CMD_CYC,
  parameter int FL_ADDR_CYC = CMM_FL_ADDR_CYC,
  parameter int FL_DUM_CYC = CMM_FL_DUM_CYC,
  parameter int FL_PIPE_CYC = CMM_FL_PIPE_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  cmm_link_if.fill link,
  output logic fill_busy,
  output logic access_start
);
  generate
    if (FL_CMD_CYC < 0 || FL_ADDR_CYC < 0 || FL_DUM_CYC < 0 || FL_PIPE_CYC < 0) begin : g_chk
      $error("cmm_fill: phase cycle counts must not be negative");
    end
  endgenerate

  typedef struct packed {
    cmm_fill_st_e st;
    logic [15:0] cnt;
    logic [15:0] rd_len;
    logic done;
  } cmm_fill_s;

  cmm_fill_s s_reg, s_next;
  logic [15:0] bytes;
  logic [15:0] fl_len;
  logic [15:0] otp_len;

  // ----------------------------------------------------------------
  // read time per source
  // ----------------------------------------------------------------
  always_comb begin
    bytes = 16'(1 << (CMM_MIN_LINE_SHIFT + int'(link.line_size)));
    fl_len = 16'(FL_CMD_CYC + FL_ADDR_CYC + FL_DUM_CYC + FL_PIPE_CYC)
      + 16'(int'(bytes) * CMM_FL_CYC_PER_BYTE);
    otp_len = 16'(int'(bytes) / CMM_OTP_BYTES_PER_CYC);
  end

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    unique case (s_reg.st)
      CMM_F_IDLE: begin
        if (link.line_req) begin
          s_next.st = CMM_F_INIT;
          s_next.cnt = '0;
          s_next.rd_len = (link.line_src == CMM_SRC_OTP) ? otp_len : fl_len;
        end
      end
      CMM_F_INIT: begin
        // access starts two cycles after the request was seen
        if (s_reg.cnt == 16'(CMM_REQ_TO_ACCESS_CYC - 2)) begin
          s_next.st = CMM_F_READ;
          s_next.cnt = '0;
        end else begin
          s_next.cnt = s_reg.cnt + 16'h1;
        end
      end
      CMM_F_READ: begin
        if (s_reg.cnt == s_reg.rd_len - 16'h1) begin
          s_next.st = CMM_F_IDLE;
          s_next.done = 1'b1;
        end else begin
          s_next.cnt = s_reg.cnt + 16'h1;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '{st: CMM_F_IDLE, cnt: 16'h0, rd_len: 16'h0, done: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.line_done = s_reg.done;
  assign fill_busy = (s_reg.st != CMM_F_IDLE);
  assign access_start = (s_reg.st == CMM_F_READ) && (s_reg.cnt == 16'h0);
endmodule : cmm_fill

// *** rtl/cmm_link_if.sv ***
`timescale 1ns/1ps
interface cmm_link_if;
  logic line_req;
  logic line_src;
  logic [1:0] line_size;
  logic [31:0] line_addr;
  logic line_done;
  modport dev (output line_req, output line_src, output line_size, output line_addr,
    input line_done);
  modport fill (input line_req, input line_src, input line_size, input line_addr,
    output line_done);
endinterface : cmm_link_if

// *** rtl/cmm_pkg.sv ***
package cmm_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CMM_CLK_NS = 10;
  localparam int CMM_MON_SPAN_MS = 10;
  localparam int CMM_MON_MAX_CYC = CMM_MON_SPAN_MS * 1000000 / CMM_CLK_NS;
  localparam int CMM_MISS_TO_REQ_CYC = 3;
  localparam int CMM_REQ_TO_ACCESS_CYC = 2;
  localparam int CMM_RETURN_CYC = 4;
  localparam int CMM_TAG_CLEAR_CYC = 450;
  localparam int CMM_FL_CMD_CYC = 2;
  localparam int CMM_FL_ADDR_CYC = 8;
  localparam int CMM_FL_DUM_CYC = 4;
  localparam int CMM_FL_PIPE_CYC = 1;
  localparam int CMM_FL_CYC_PER_BYTE = 2;
  localparam int CMM_OTP_BYTES_PER_CYC = 4;
  // ----------------------------------------------------------------
  // line size codes
  // ----------------------------------------------------------------
  localparam logic [1:0] CMM_LINE_8 = 2'h0;
  localparam logic [1:0] CMM_LINE_16 = 2'h1;
  localparam logic [1:0] CMM_LINE_32 = 2'h2;
  localparam int CMM_MIN_LINE_SHIFT = 3;
  localparam logic CMM_SRC_FLASH = 1'b0;
  localparam logic CMM_SRC_OTP = 1'b1;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CMM_CTRL_OFS = 8'h00;
  localparam logic [7:0] CMM_LINE_CFG_OFS = 8'h04;
  localparam logic [7:0] CMM_INTERVAL_OFS = 8'h08;
  localparam logic [7:0] CMM_THRESH_OFS = 8'h0c;
  localparam logic [7:0] CMM_HIT_CNT_OFS = 8'h10;
  localparam logic [7:0] CMM_MISS_CNT_OFS = 8'h14;
  localparam logic [7:0] CMM_IRQ_STAT_OFS = 8'h18;
  localparam logic [7:0] CMM_IRQ_CLR_OFS = 8'h1c;
  localparam logic [7:0] CMM_IRQ_EN_OFS = 8'h20;
  localparam logic [7:0] CMM_STATUS_OFS = 8'h24;
  localparam int CMM_CTRL_MON_EN_BIT = 0;
  localparam int CMM_CTRL_SOFT_RST_BIT = 1;
  localparam int CMM_IRQ_THRESH_BIT = 0;
  localparam int CMM_IRQ_INTERVAL_BIT = 1;
  localparam logic [31:0] CMM_THRESH_RST = 32'h0000_0000;
  localparam logic [31:0] CMM_INTERVAL_RST = 32'(CMM_MON_MAX_CYC);
  // ----------------------------------------------------------------
  // state machines
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {CMM_CLEAR, CMM_IDLE, CMM_MISS, CMM_WAIT, CMM_RET} cmm_dev_st_e;
  typedef enum logic [1:0] {CMM_F_IDLE, CMM_F_INIT, CMM_F_READ} cmm_fill_st_e;
endpackage : cmm_pkg

// *** sim/cache_miss_monitor_latency_bench.sv ***
`timescale 1ns/1ps
module cache_miss_monitor_latency_bench
  import cmm_pkg::*;
  ;
  localparam int CLR = 16;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, sys_active, irq;
  logic fetch_valid, fetch_src, fetch_ready, fill_busy, access_start;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, fetch_addr, q;
  logic [7:0] ofs [6];
  logic [31:0] dft [6];
  int miscompares, checks_done, n, rq, b;
  cmm_link_if cmm_link_if_inst ();
  cmm_cache #(.TAG_INDEX_W(4)) cmm_cache_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .fetch_src(fetch_src), .fetch_ready(fetch_ready),
    .sys_active(sys_active), .irq(irq), .link(cmm_link_if_inst.dev));
  cmm_fill cmm_fill_inst (
    .hclk(hclk), .hresetn(hresetn), .link(cmm_link_if_inst.fill),
    .fill_busy(fill_busy), .access_start(access_start));
  cmm_properties #(.TAG_INDEX_W(4)) cmm_properties_inst (
    .hclk(hclk), .hresetn(hresetn), .line_req(cmm_link_if_inst.line_req),
    .line_src(cmm_link_if_inst.line_src), .line_size(cmm_link_if_inst.line_size),
    .line_addr(cmm_link_if_inst.line_addr), .line_done(cmm_link_if_inst.line_done),
    .fill_busy(fill_busy), .access_start(access_start), .fetch_ready(fetch_ready));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // ----------------
  // access tasks
  // ----------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic hang(input logic ok);
    if (!ok) begin
      miscompares++;
      close_out();
    end
  endtask : hang
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    // address phase, then data phase; each ends on hready sampled high
    for (int p = 0; p < 2; p++) begin
      k = 0;
      do begin
        @(posedge hclk);
        k++;
      end while (hreadyout !== 1'b1 && k < 64);
      hang(hreadyout === 1'b1);
      // release once only, so a following call drives each signal once per step
      if (p == 0) begin
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
      end
    end
    q = hrdata;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
    bus(1'b0, a, 32'h0);
    chk(what, q, e);
  endtask : rd
  task automatic fetch(input logic [31:0] a, input logic s);
    fetch_addr <= a;
    fetch_src <= s;
    fetch_valid <= 1'b1;
    n = -1;
    rq = -1;
    do begin
      @(posedge hclk);
      n++;
      if (cmm_link_if_inst.line_req === 1'b1 && rq < 0) rq = n;
    end while (fetch_ready !== 1'b1 && n < 3000);
    hang(fetch_ready === 1'b1);
    fetch_valid <= 1'b0;
    // idle cycle so the next request is a fresh edge
    @(posedge hclk);
  endtask : fetch
  task automatic wait_end();
    int k;
    k = 0;
    do begin
      bus(1'b0, CMM_IRQ_STAT_OFS, 32'h0);
      k++;
    end while (q[1] !== 1'b1 && k < 2000);
    hang(q[1] === 1'b1);
  endtask : wait_end
  initial begin
    {hresetn, hsel, hwrite, htrans, fetch_valid, fetch_src} = '0;
    {haddr, hwdata, fetch_addr} = '0;
    hsize = 3'h2;
    sys_active = 1'b1;
    miscompares = 0;
    checks_done = 0;
    ofs = '{CMM_CTRL_OFS, CMM_LINE_CFG_OFS, CMM_INTERVAL_OFS, CMM_THRESH_OFS,
      CMM_IRQ_EN_OFS, 8'h40};
    dft = '{32'h0, 32'h0, 32'h000f4240, 32'h0, 32'h0, 32'h0};
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    fetch(32'h40, CMM_SRC_FLASH);
    chk("hold", 32'(n), 32'(CLR + 40));
    for (int i = 0; i < 6; i++) rd(ofs[i], dft[i], "dflt");
    chk("hresp", {31'h0, hresp}, 32'h0);
    bus(1'b1, CMM_THRESH_OFS, 32'h3);
    bus(1'b1, CMM_CTRL_OFS, 32'h1);
    bus(1'b1, CMM_INTERVAL_OFS, 32'h5dc);
    for (int i = 0; i < 6; i++) begin
      b = 8 << (i % 3);
      bus(1'b1, CMM_LINE_CFG_OFS, 32'(i % 3));
      fetch(32'(i + 1) << 8, 1'(i >= 3));
      chk("miss", 32'(n), 32'(i >= 3 ? 9 + b / 4 : 24 + 2 * b));
      chk("req", 32'(rq), 32'h3);
      fetch(32'(i + 1) << 8, 1'(i >= 3));
      chk("hit", 32'(n), 32'h0);
    end
    bus(1'b1, CMM_LINE_CFG_OFS, 32'h3);
    rd(CMM_LINE_CFG_OFS, 32'h2, "size");
    wait_end();
    rd(CMM_IRQ_STAT_OFS, 32'h3, "stat");
    chk("mask", {31'h0, irq}, 32'h0);
    rd(CMM_HIT_CNT_OFS, 32'h6, "hits");
    rd(CMM_MISS_CNT_OFS, 32'h6, "misses");
    bus(1'b1, CMM_IRQ_EN_OFS, 32'h3);
    @(posedge hclk);
    chk("irq", {31'h0, irq}, 32'h1);
    bus(1'b1, CMM_IRQ_CLR_OFS, 32'h3);
    @(posedge hclk);
    chk("clr", {31'h0, irq}, 32'h0);
    sys_active <= 1'b0;
    fetch(32'h4000, CMM_SRC_FLASH);
    fetch(32'h4000, CMM_SRC_FLASH);
    sys_active <= 1'b1;
    wait_end();
    rd(CMM_IRQ_STAT_OFS, 32'h2, "once");
    rd(CMM_HIT_CNT_OFS, 32'h0, "idle_hits");
    rd(CMM_MISS_CNT_OFS, 32'h0, "idle_misses");
    bus(1'b1, CMM_CTRL_OFS, 32'h3);
    rd(CMM_CTRL_OFS, 32'h1, "ctrl");
    rd(CMM_LINE_CFG_OFS, 32'h2, "keep");
    rd(CMM_INTERVAL_OFS, 32'h5dc, "intv");
    fetch(32'h4000, CMM_SRC_FLASH);
    chk("soft", 32'(rq >= 0 && n >= 88), 32'h1);
    close_out();
  end
endmodule : cache_miss_monitor_latency_bench

// *** sim/cmm_properties.sv ***
`timescale 1ns/1ps
module cmm_properties
  import cmm_pkg::*;
#(
  parameter int TAG_INDEX_W = 9
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic line_req,
  input wire logic line_src,
  input wire logic [1:0] line_size,
  input wire logic [31:0] line_addr,
  input wire logic line_done,
  input wire logic fill_busy,
  input wire logic access_start,
  input wire logic fetch_ready
);
  // ----------------
  // fill timing model
  // ----------------
  localparam int CLR = 1 << TAG_INDEX_W;
  logic [7:0] nb, len, cnt_reg, exp_reg;
  logic on_reg;
  logic [15:0] clr_reg;
  assign nb = 8'h08 << line_size;
  // flash: 2 start + 15 fixed phases + 2 per byte; otp: 2 start + bytes/4
  assign len = line_src ? 8'h02 + (nb >> 2) : 8'h11 + (nb << 1);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 8'h00;
      exp_reg <= 8'h00;
      on_reg <= 1'b0;
      clr_reg <= 16'h0000;
    end else begin
      // saturates so a long run cannot wrap back into the clear window
      if (clr_reg < 16'(CLR)) begin
        clr_reg <= clr_reg + 16'h0001;
      end
      cnt_reg <= line_req ? 8'h01 : cnt_reg + 8'h01;
      if (line_req) begin
        exp_reg <= len;
      end
      on_reg <= line_req | (on_reg & ~line_done);
    end
  end
  // ----------------
  // link properties
  // ----------------
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_access;
    ##2 access_start;
  endsequence
  sequence s_return;
    !fetch_ready [*3] ##1 fetch_ready ##1 !fetch_ready;
  endsequence
  a_req_pulse: assert property (line_req |=> !line_req)
    else $error("line request too long");
  a_access_delay: assert property (line_req |-> s_access)
    else $error("access start late or missing");
  a_access_cause: assert property (access_start |-> $past(line_req, 2))
    else $error("access start without request");
  a_fill_length: assert property (line_done == (on_reg && cnt_reg == exp_reg))
    else $error("line done at wrong cycle");
  a_done_pulse: assert property (line_done |=> !line_done)
    else $error("line done too long");
  a_word_return: assert property (line_done |=> s_return)
    else $error("word return not four cycles after data");
  a_link_hold: assert property (on_reg && !line_req |->
    $stable(line_addr) && $stable(line_size) && $stable(line_src))
    else $error("request fields moved during fill");
  a_one_fill: assert property (fill_busy |-> !line_req)
    else $error("request while fill busy");
  a_busy_after: assert property (line_req |=> fill_busy)
    else $error("fill not busy after request");
  a_clear_hold: assert property ((fetch_ready || line_req) |->
    clr_reg >= 16'(CLR - 1))
    else $error("fetch served during tag clear");
endmodule : cmm_properties
